// [rtl/dsp_ext_regs.svh]
// Register map, field positions and codes of the signal-processing state block
`ifndef DSP_EXT_REGS_SVH
`define DSP_EXT_REGS_SVH
`define CTRL_OFS 8'h00
`define CFG3_OFS 8'h04
`define ENABLE_OFS 8'h08
`define IRQ_STAT_OFS 8'h0C
`define IRQ_MASK_OFS 8'h10
`define ACC_BASE 3'h1
`define CCOND_HI 27
`define CCOND_LO 24
`define OUFLAG_HI 23
`define OUFLAG_LO 16
`define EFI_BIT 14
`define CARRY_BIT 13
`define SIZE_HI 12
`define SIZE_LO 7
`define POS_HI 5
`define POS_LO 0
`define OU_ACC_BASE 3'h0
`define OU_ADD_BIT 20
`define OU_MUL_BIT 21
`define OU_SHIFT_BIT 22
`define OU_EXTR_BIT 23
`define PRESENT_BIT 0
`define REV2_BIT 1
`define POS_STEP 6'h20
`define CAUSE_DISABLED 5'h1A
`define WM_POS 0
`define WM_SIZE 1
`define WM_CARRY 2
`define WM_OUFLAG 3
`define WM_CCOND 4
`define WM_EFI 5
`define IRQ_OVF 0
`define IRQ_EFI 1
`define IRQ_DIS 2
`define IRQ_BITS 3
`define CTRL_RESET 32'h0000_0000
`endif

// [rtl/dsp_ext_pkg.sv]
// Types shared by the signal-processing state block and its users
package dsp_ext_pkg;
  typedef enum logic [3:0] {
    OP_NONE, OP_CMP, OP_ACC_SAT, OP_ADD, OP_ADD_SET_CARRY, OP_ADD_WITH_CARRY, OP_MUL,
    OP_SHIFT, OP_EXTR, OP_EXTRACT_POS, OP_EXTRACT_DEC, OP_VARIABLE_BIT_INSERT, OP_COPY_LHI,
    OP_WRITE_CTRL, OP_ACC_MOVE, OP_OTHER
  } op_kind_t;
  typedef struct packed {
    logic valid;
    op_kind_t kind;
    logic [1:0] acc;
    logic ovf;
    logic [2:0] cmp_count;
    logic [3:0] cmp_bits;
    logic carry_out;
    logic [5:0] size;
    logic [5:0] field_mask;
    logic [31:0] ctrl_data;
    logic acc_wr;
    logic [31:0] acc_hi;
    logic [31:0] acc_lo;
  } dsp_op_t;
  typedef struct packed {
    logic [3:0] ccond;
    logic carry;
    logic [5:0] insert_size;
    logic [5:0] position;
    logic extract_fail;
    logic enable;
  } dsp_state_t;
  typedef struct packed {
    logic [31:0] hi;
    logic [31:0] lo;
  } acc_pair_t;
endpackage

// [rtl/dsp_extension_state.sv]
// Accumulator pairs, control/status word and access gating of the extension
// Functional notes
// - Four accumulator pairs exist, selected by a two-bit field where zero is the base pair.
// - Reserved control bits, 31:28 included, read as zero and software writes zeros there.
// - A vector compare writes only the lowest condition bits, one per element, others keep.
// - Overflow flags 23:16 are set by hardware, sticky, and cleared only by a control write.
// - Saturating dot/multiply-accumulate overflow sets flag 16 plus the destination pair index.
// - Absolute, add, subtract and add-with-carry overflow sets flag bit 20.
// - Element multiply overflow, rounding or saturating, sets flag bit 21.
// - Precision-reduce and left-shift overflow sets flag bit 22.
// - Accumulator extract-with-right-shift overflow sets flag bit 23.
// - Each position extract writes the non-sticky fail flag at bit 14 as position below size.
// - Variable bit-insert takes its field width from the size field 12:7.
// - Position field 5:0 gives the insert position and the extract position.
// - Decrement-position extracts that do not fail reduce the position field by the extracted size.
// - Copy-low-to-high-and-insert moves the low word to the high word and adds 32 to position.
// - Two read-only bits advertise the extension and its second revision, both fixed at one.
// - With the enable bit clear, extension ops or moves on pairs 1 to 3 raise cause code 26.
`timescale 1ns/1ps
`include "dsp_ext_regs.svh"
module dsp_extension_state #(
  parameter int ADDR_WIDTH = 8,
  parameter int ACC_PAIRS = 4
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Avalon-MM register slave
  input wire logic [ADDR_WIDTH-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Instruction side
  input wire dsp_ext_pkg::dsp_op_t op,
  output dsp_ext_pkg::dsp_state_t state,
  output logic exc_pulse,
  output logic [4:0] exc_code,
  // Accumulator read port
  input wire logic [1:0] acc_rd_sel,
  output dsp_ext_pkg::acc_pair_t acc_rd_data,
  // Interrupt
  output logic irq
);
  import dsp_ext_pkg::*;

  // Address decode reads bits 7:2, so narrower buses cannot reach every register
  if (ADDR_WIDTH < 8 || ACC_PAIRS != 4) begin : g_check
    $error("dsp_extension_state: ADDR_WIDTH must be >= 8 and ACC_PAIRS must be 4");
  end

  logic waitrequest_reg;
  logic [31:0] readdata_reg;
  logic enable_reg;
  logic [3:0] ccond_reg;
  logic [3:0] ccond_next;
  logic [7:0] ouflag_reg;
  logic [7:0] ouflag_next;
  logic [7:0] ouflag_set;
  logic efi_reg;
  logic efi_next;
  logic carry_reg;
  logic carry_next;
  logic [5:0] size_reg;
  logic [5:0] size_next;
  logic [5:0] pos_reg;
  logic [5:0] pos_next;
  logic [`IRQ_BITS-1:0] irq_stat_reg;
  logic [`IRQ_BITS-1:0] irq_stat_next;
  logic [`IRQ_BITS-1:0] irq_mask_reg;
  logic [`IRQ_BITS-1:0] irq_event;
  logic irq_reg;
  logic exc_pulse_reg;
  logic [4:0] exc_code_reg;
  acc_pair_t acc_reg [ACC_PAIRS];
  acc_pair_t acc_rd_reg;
  logic [31:0] ctrl_word;
  logic [31:0] ctrl_bus;
  logic [31:0] wmask;
  logic [31:0] rd_mux;
  logic [7:0] word_addr;
  logic bus_wr;
  logic ctrl_wr;
  logic blocked;
  logic take;
  logic extract_op;
  logic extract_fail;
  logic wr_ctrl;

  // Bus handshake: one wait cycle, then the access completes
  assign bus_wr = write && !waitrequest_reg;
  assign word_addr = {address[7:2], 2'b00};
  assign wmask = {{8{byteenable[3]}}, {8{byteenable[2]}}, {8{byteenable[1]}},
                  {8{byteenable[0]}}};
  assign ctrl_wr = bus_wr && (word_addr == `CTRL_OFS);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      waitrequest_reg <= 1'b1;
    end else if ((read || write) && waitrequest_reg) begin
      waitrequest_reg <= 1'b0;
    end else begin
      waitrequest_reg <= 1'b1;
    end
  end

  always_comb begin
    ctrl_word = `CTRL_RESET;
    ctrl_word[`CCOND_HI:`CCOND_LO] = ccond_reg;
    ctrl_word[`OUFLAG_HI:`OUFLAG_LO] = ouflag_reg;
    ctrl_word[`EFI_BIT] = efi_reg;
    ctrl_word[`CARRY_BIT] = carry_reg;
    ctrl_word[`SIZE_HI:`SIZE_LO] = size_reg;
    ctrl_word[`POS_HI:`POS_LO] = pos_reg;
  end

  assign ctrl_bus = (ctrl_word & ~wmask) | (writedata & wmask);

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (word_addr)
      `CTRL_OFS: rd_mux = ctrl_word;
      `CFG3_OFS: begin
        rd_mux[`PRESENT_BIT] = 1'b1;
        rd_mux[`REV2_BIT] = 1'b1;
      end
      `ENABLE_OFS: rd_mux[0] = enable_reg;
      `IRQ_STAT_OFS: rd_mux[`IRQ_BITS-1:0] = irq_stat_reg;
      `IRQ_MASK_OFS: rd_mux[`IRQ_BITS-1:0] = irq_mask_reg;
      default: begin
        if (word_addr[7:5] == `ACC_BASE) begin
          rd_mux = word_addr[2] ? acc_reg[word_addr[4:3]].hi : acc_reg[word_addr[4:3]].lo;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      readdata_reg <= 32'h0000_0000;
    end else if (read && waitrequest_reg) begin
      readdata_reg <= rd_mux;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      enable_reg <= 1'b0;
    end else if (bus_wr && word_addr == `ENABLE_OFS && byteenable[0]) begin
      enable_reg <= writedata[0];
    end
  end

  assign blocked = op.valid && !enable_reg && (op.kind != OP_NONE)
                   && (op.kind != OP_ACC_MOVE || op.acc != 2'b00);
  assign take = op.valid && !blocked;
  assign wr_ctrl = take && op.kind == OP_WRITE_CTRL;
  assign extract_op = take && (op.kind == OP_EXTRACT_POS || op.kind == OP_EXTRACT_DEC);
  assign extract_fail = pos_reg < op.size;

  always_comb begin
    ccond_next = ctrl_wr ? ctrl_bus[`CCOND_HI:`CCOND_LO] : ccond_reg;
    if (wr_ctrl && op.field_mask[`WM_CCOND]) begin
      ccond_next = op.ctrl_data[`CCOND_HI:`CCOND_LO];
    end
    if (take && op.kind == OP_CMP) begin
      for (int i = 0; i < 4; i++) begin
        if (i < int'(op.cmp_count)) begin
          ccond_next[i] = op.cmp_bits[i];
        end
      end
    end
  end

  always_comb begin
    ouflag_set = 8'h00;
    if (take && op.ovf) begin
      case (op.kind)
        OP_ACC_SAT: ouflag_set[{1'b0, op.acc}] = 1'b1;
        OP_ADD, OP_ADD_WITH_CARRY: ouflag_set[`OU_ADD_BIT-`OUFLAG_LO] = 1'b1;
        OP_MUL: ouflag_set[`OU_MUL_BIT-`OUFLAG_LO] = 1'b1;
        OP_SHIFT: ouflag_set[`OU_SHIFT_BIT-`OUFLAG_LO] = 1'b1;
        OP_EXTR: ouflag_set[`OU_EXTR_BIT-`OUFLAG_LO] = 1'b1;
        default: ouflag_set = 8'h00;
      endcase
    end
    // sticky, set wins over any clear
    ouflag_next = ctrl_wr ? ctrl_bus[`OUFLAG_HI:`OUFLAG_LO] : ouflag_reg;
    if (wr_ctrl && op.field_mask[`WM_OUFLAG]) begin
      ouflag_next = op.ctrl_data[`OUFLAG_HI:`OUFLAG_LO];
    end
    ouflag_next = ouflag_next | ouflag_set;
  end

  always_comb begin
    efi_next = ctrl_wr ? ctrl_bus[`EFI_BIT] : efi_reg;
    carry_next = ctrl_wr ? ctrl_bus[`CARRY_BIT] : carry_reg;
    size_next = ctrl_wr ? ctrl_bus[`SIZE_HI:`SIZE_LO] : size_reg;
    pos_next = ctrl_wr ? ctrl_bus[`POS_HI:`POS_LO] : pos_reg;
    if (wr_ctrl) begin
      if (op.field_mask[`WM_EFI]) begin
        efi_next = op.ctrl_data[`EFI_BIT];
      end
      if (op.field_mask[`WM_CARRY]) begin
        carry_next = op.ctrl_data[`CARRY_BIT];
      end
      if (op.field_mask[`WM_SIZE]) begin
        size_next = op.ctrl_data[`SIZE_HI:`SIZE_LO];
      end
      if (op.field_mask[`WM_POS]) begin
        pos_next = op.ctrl_data[`POS_HI:`POS_LO];
      end
    end
    if (extract_op) begin
      efi_next = extract_fail;
    end
    if (take && op.kind == OP_ADD_SET_CARRY) begin
      carry_next = op.carry_out;
    end
    if (extract_op && op.kind == OP_EXTRACT_DEC && !extract_fail) begin
      pos_next = pos_reg - op.size;
    end
    if (take && op.kind == OP_COPY_LHI) begin
      pos_next = pos_reg + `POS_STEP;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ccond_reg <= 4'h0;
    end else begin
      ccond_reg <= ccond_next;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ouflag_reg <= 8'h00;
    end else begin
      ouflag_reg <= ouflag_next;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      efi_reg <= 1'b0;
    end else begin
      efi_reg <= efi_next;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      carry_reg <= 1'b0;
    end else begin
      carry_reg <= carry_next;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      size_reg <= 6'h00;
    end else begin
      size_reg <= size_next;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pos_reg <= 6'h00;
    end else begin
      pos_reg <= pos_next;
    end
  end

  // four pairs, pair zero is the base
  for (genvar g = 0; g < ACC_PAIRS; g++) begin : g_acc
    logic sel;
    logic bus_hit;
    assign sel = take && op.acc == 2'(g);
    assign bus_hit = bus_wr && word_addr[7:5] == `ACC_BASE && word_addr[4:3] == 2'(g);
    always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
        acc_reg[g] <= '0;
      end else if (sel && op.kind == OP_COPY_LHI) begin
        acc_reg[g].hi <= acc_reg[g].lo;
        acc_reg[g].lo <= op.acc_lo;
      end else if (sel && op.acc_wr) begin
        acc_reg[g].hi <= op.acc_hi;
        acc_reg[g].lo <= op.acc_lo;
      end else if (bus_hit && word_addr[2]) begin
        acc_reg[g].hi <= (acc_reg[g].hi & ~wmask) | (writedata & wmask);
      end else if (bus_hit) begin
        acc_reg[g].lo <= (acc_reg[g].lo & ~wmask) | (writedata & wmask);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      acc_rd_reg <= '0;
    end else begin
      acc_rd_reg <= acc_reg[acc_rd_sel];
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      exc_pulse_reg <= 1'b0;
      exc_code_reg <= 5'h00;
    end else begin
      exc_pulse_reg <= blocked;
      if (blocked) begin
        exc_code_reg <= `CAUSE_DISABLED;
      end
    end
  end

  // Interrupt status: event set beats a write-one clear
  always_comb begin
    irq_event = '0;
    irq_event[`IRQ_OVF] = |(ouflag_set & ~ouflag_reg);
    irq_event[`IRQ_EFI] = extract_op && extract_fail;
    irq_event[`IRQ_DIS] = blocked;
    irq_stat_next = irq_stat_reg;
    if (bus_wr && word_addr == `IRQ_STAT_OFS && byteenable[0]) begin
      irq_stat_next = irq_stat_reg & ~writedata[`IRQ_BITS-1:0];
    end
    irq_stat_next = irq_stat_next | irq_event;
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
      irq_reg <= 1'b0;
    end else begin
      irq_stat_reg <= irq_stat_next;
      if (bus_wr && word_addr == `IRQ_MASK_OFS && byteenable[0]) begin
        irq_mask_reg <= writedata[`IRQ_BITS-1:0];
        irq_reg <= |(irq_stat_next & writedata[`IRQ_BITS-1:0]);
      end else begin
        irq_reg <= |(irq_stat_next & irq_mask_reg);
      end
    end
  end

  assign readdata = readdata_reg;
  assign waitrequest = waitrequest_reg;
  assign exc_pulse = exc_pulse_reg;
  assign exc_code = exc_code_reg;
  assign acc_rd_data = acc_rd_reg;
  assign irq = irq_reg;
  assign state = '{ccond: ccond_reg, carry: carry_reg, insert_size: size_reg,
                   position: pos_reg, extract_fail: efi_reg, enable: enable_reg};
endmodule

// [dv/dsp_ext_checker_assertions.sv]
// Port checker of the extension state block
`timescale 1ns/1ps
module dsp_ext_checker #(
  parameter int ADDR_WIDTH = 8
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Register bus
  input wire logic [ADDR_WIDTH-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // Instruction side
  input wire dsp_ext_pkg::dsp_op_t op,
  input wire dsp_ext_pkg::dsp_state_t state,
  input wire logic exc_pulse,
  input wire logic [4:0] exc_code
);
  import dsp_ext_pkg::*;
  logic run;
  logic blocked;
  logic [3:0] cmp_mask;
  assign run = op.valid && state.enable;
  assign blocked = op.valid && !state.enable && op.kind != OP_NONE
    && !(op.kind == OP_ACC_MOVE && op.acc == 2'h0);
  assign cmp_mask = 4'((5'h01 << op.cmp_count) - 5'h01);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  ctrl_reserved_a: assert property (read && !waitrequest && address[7:2] == 6'h00 |->
    readdata[31:28] == 4'h0 && readdata[15] == 1'b0 && readdata[6] == 1'b0)
    else $error("reserved control bits read nonzero");
  present_bits_a: assert property (read && !waitrequest && address[7:2] == 6'h01 |->
    readdata[1:0] == 2'h3) else $error("present bits not both one");
  ccond_update_a: assert property (run && op.kind == OP_CMP |=> state.ccond ==
    (($past(state.ccond) & ~$past(cmp_mask)) | ($past(op.cmp_bits) & $past(cmp_mask))))
    else $error("condition bits wrong after compare");
  extract_fail_a: assert property (run && op.kind inside {OP_EXTRACT_POS, OP_EXTRACT_DEC}
    |=> state.extract_fail == ($past(state.position) < $past(op.size)))
    else $error("extract fail flag wrong");
  pos_decrement_a: assert property (run && op.kind == OP_EXTRACT_DEC &&
    state.position >= op.size |=> state.position == $past(state.position) - $past(op.size))
    else $error("position not reduced by size");
  pos_step_a: assert property (run && op.kind == OP_COPY_LHI |=>
    state.position == $past(state.position) + 6'h20) else $error("position not stepped");
  carry_set_a: assert property (run && op.kind == OP_ADD_SET_CARRY |=>
    state.carry == $past(op.carry_out)) else $error("carry bit not taken");
  blocked_exc_a: assert property (blocked |=> exc_pulse && exc_code == 5'h1A)
    else $error("blocked op raised no exception");
  blocked_hold_a: assert property (blocked && !write |=> $stable(state))
    else $error("blocked op changed state");
endmodule
bind dsp_extension_state dsp_ext_checker #(.ADDR_WIDTH(ADDR_WIDTH)) chk_u (.ref_clk, .resetn,
  .address, .read, .write, .readdata, .waitrequest, .op, .state, .exc_pulse, .exc_code);

// [dv/test_dsp_extension_state.sv]
// Self-checking bench of the extension state block
`timescale 1ns/1ps
`include "dsp_ext_regs.svh"
module test_dsp_extension_state;
  import dsp_ext_pkg::*;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [3:0] byteenable = 4'hF;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest;
  dsp_op_t op = '0;
  dsp_state_t state;
  logic exc_pulse;
  logic [4:0] exc_code;
  logic [1:0] acc_rd_sel = 2'h0;
  acc_pair_t acc_rd_data;
  logic irq;
  logic [31:0] rd;
  logic ex_seen;
  int bad_count = 0;
  int n_compared = 0;
  always #20 ref_clk = ~ref_clk;
  dsp_extension_state dut_u (.ref_clk, .resetn, .address, .read, .write, .byteenable,
    .writedata, .readdata, .waitrequest, .op, .state, .exc_pulse, .exc_code, .acc_rd_sel,
    .acc_rd_data, .irq);
  task automatic test_done();
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Waits for the answer edge, bounded
  task automatic wait_ack();
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (waitrequest !== 1'b0) begin
      check(32'h1, 32'h0);
      test_done();
    end
  endtask
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    address <= a;
    writedata <= d;
    write <= 1'b1;
    wait_ack();
    write <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic bus_rd(input logic [7:0] a);
    address <= a;
    read <= 1'b1;
    wait_ack();
    rd = readdata;
    read <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic do_op(input dsp_op_t o);
    op <= o;
    @(posedge ref_clk);
    op <= '0;
    @(negedge ref_clk);
    ex_seen = exc_pulse;
    @(posedge ref_clk);
  endtask
  function automatic dsp_op_t mk(input op_kind_t k, input logic [1:0] a, input logic v);
    dsp_op_t o;
    o = '0;
    o.valid = 1'b1;
    o.kind = k;
    o.acc = a;
    o.ovf = v;
    return o;
  endfunction
  initial begin
    repeat (4000) @(posedge ref_clk);
    bad_count++;
    test_done();
  end
  initial begin
    dsp_op_t o;
    logic [7:0] exp_ou;
    repeat (20) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    bus_rd(`CTRL_OFS);
    check(rd, 32'h0);
    bus_wr(`CFG3_OFS, 32'h0);
    bus_rd(`CFG3_OFS);
    check(rd & 32'h3, 32'h3);
    bus_wr(8'h40, 32'hFFFF_FFFF);
    bus_rd(8'h40);
    check(rd, 32'h0);
    // Disabled access, masked then unmasked interrupt
    do_op(mk(OP_ADD, 2'h0, 1'b1));
    check(ex_seen, 1'b1);
    check(exc_code, `CAUSE_DISABLED);
    check(irq, 1'b0);
    do_op(mk(OP_ACC_MOVE, 2'h0, 1'b0));
    check(ex_seen, 1'b0);
    do_op(mk(OP_ACC_MOVE, 2'h1, 1'b0));
    check(ex_seen, 1'b1);
    bus_wr(`IRQ_MASK_OFS, 32'h4);
    @(negedge ref_clk);
    check(irq, 1'b1);
    @(posedge ref_clk);
    bus_wr(`IRQ_STAT_OFS, 32'h4);
    @(negedge ref_clk);
    check(irq, 1'b0);
    @(posedge ref_clk);
    bus_rd(`CTRL_OFS);
    check(rd, 32'h0);
    bus_wr(`ENABLE_OFS, 32'h1);
    check(state.enable, 1'b1);
    bus_wr(`CTRL_OFS, 32'h0FFF_7FBF);
    bus_rd(`CTRL_OFS);
    check(rd, 32'h0FFF_7FBF);
    check(state.insert_size, 6'h3F);
    check(state.position, 6'h3F);
    bus_wr(`CTRL_OFS, 32'h0);
    // Overflow flags accumulate per class and pair
    exp_ou = 8'h00;
    do_op(mk(OP_ADD, 2'h0, 1'b0));
    for (int i = 0; i < 9; i++) begin
      do_op(mk(i < 4 ? OP_ACC_SAT : (i == 4 ? OP_ADD : op_kind_t'(i)), 2'(i), 1'b1));
      exp_ou[i < 4 ? i : (i < 6 ? 4 : i - 1)] = 1'b1;
      bus_rd(`CTRL_OFS);
      check(rd, {8'h0, exp_ou, 16'h0});
    end
    o = mk(OP_WRITE_CTRL, 2'h0, 1'b0);
    o.field_mask = 6'h08;
    do_op(o);
    bus_rd(`CTRL_OFS);
    check(rd, 32'h0);
    o = mk(OP_CMP, 2'h0, 1'b0);
    o.cmp_count = 3'h2;
    o.cmp_bits = 4'hF;
    do_op(o);
    check(state.ccond, 4'h3);
    o.cmp_count = 3'h1;
    o.cmp_bits = 4'h0;
    do_op(o);
    check(state.ccond, 4'h2);
    // Control-write instruction with every field but the flags selected
    o = mk(OP_WRITE_CTRL, 2'h0, 1'b0);
    o.field_mask = 6'h37;
    o.ctrl_data = 32'h0FFF_7FBF;
    do_op(o);
    bus_rd(`CTRL_OFS);
    check(rd, 32'h0F00_7FBF);
    bus_wr(`CTRL_OFS, 32'h5);
    o = mk(OP_EXTRACT_POS, 2'h0, 1'b0);
    o.size = 6'h6;
    do_op(o);
    check(state.extract_fail, 1'b1);
    check(state.position, 6'h5);
    o.kind = OP_EXTRACT_DEC;
    o.size = 6'h5;
    do_op(o);
    check(state.extract_fail, 1'b0);
    check(state.position, 6'h0);
    o.size = 6'h1;
    do_op(o);
    check(state.extract_fail, 1'b1);
    check(state.position, 6'h0);
    o = mk(OP_ADD_SET_CARRY, 2'h0, 1'b0);
    o.carry_out = 1'b1;
    do_op(o);
    check(state.carry, 1'b1);
    o.carry_out = 1'b0;
    do_op(o);
    check(state.carry, 1'b0);
    // Copy low to high on pair 2, position wraps
    bus_wr(8'h30, 32'h1234_5678);
    bus_wr(`CTRL_OFS, 32'h30);
    o = mk(OP_COPY_LHI, 2'h2, 1'b0);
    o.acc_lo = 32'hAAAA_0000;
    do_op(o);
    check(state.position, 6'h10);
    acc_rd_sel <= 2'h2;
    @(posedge ref_clk);
    @(negedge ref_clk);
    check(acc_rd_data.hi, 32'h1234_5678);
    check(acc_rd_data.lo, 32'hAAAA_0000);
    @(posedge ref_clk);
    // Instruction write to pair 3, read back over the bus
    o = mk(OP_ACC_MOVE, 2'h3, 1'b0);
    o.acc_wr = 1'b1;
    o.acc_hi = 32'h5555_0001;
    do_op(o);
    check(ex_seen, 1'b0);
    bus_rd(8'h3C);
    check(rd, 32'h5555_0001);
    bus_rd(8'h20);
    check(rd, 32'h0);
    test_done();
  end
endmodule
